// >>> hdl/flic_defs.vh
`ifndef FLIC_DEFS_VH
`define FLIC_DEFS_VH

`define FLIC_NUM_SRC      19
`define FLIC_SRC_W        5
`define FLIC_SRC_EXT_A    5'h00
`define FLIC_SRC_TMR_A    5'h01
`define FLIC_SRC_EXT_B    5'h02
`define FLIC_SRC_TMR_B    5'h03
`define FLIC_SRC_SER_A    5'h04
`define FLIC_SRC_TMR_C    5'h05
`define FLIC_SRC_EXT_C    5'h06
`define FLIC_SRC_SPI      5'h07
`define FLIC_SRC_ADC      5'h08
`define FLIC_SRC_ARRAY    5'h09
`define FLIC_SRC_SYSF     5'h0a
`define FLIC_SRC_KEYPAD   5'h0b
`define FLIC_SRC_TWI      5'h0c
`define FLIC_SRC_SER_B    5'h0e
`define FLIC_SRC_TMR_D    5'h10
`define FLIC_SRC_DMA      5'h12
`define FLIC_RESERVED_MSK 19'h2a000
`define FLIC_VEC_BASE     16'h0003
`define FLIC_VEC_STEP_SH  3
`define FLIC_LVL_W        2
`define FLIC_LVL_RST      2'h0
`define FLIC_ST_IDLE      2'h0
`define FLIC_ST_POLL      2'h1
`define FLIC_ST_CALL      2'h2

`endif

// >>> hdl/flic_ext_input.v
`timescale 1ns/1ps
`include "flic_defs.vh"

module flic_ext_input (
  input  wire clk_sys_in,
  input  wire rst_n_in,
  input  wire pin_in,
  input  wire high_active_in,
  input  wire type_select_in,
  input  wire sw_set_in,
  input  wire sw_clr_in,
  input  wire vector_taken_in,
  output reg  flag_out
);

  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  wire active;
  wire edge_seen;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign active    = high_active_in ? sync2_q : ~sync2_q;
  assign edge_seen = active & ~(high_active_in ? prev_q : ~prev_q);

  // Edge mode: sticky, set beats clear; level mode: follows the pin
  always @(posedge clk_sys_in) begin
    if (!rst_n_in)
      flag_out <= 1'b0;
    else if (type_select_in) begin
      if (edge_seen | sw_set_in)
        flag_out <= 1'b1;
      else if (vector_taken_in | sw_clr_in)
        flag_out <= 1'b0;
    end else
      flag_out <= active | sw_set_in;
  end

endmodule

// >>> hdl/flic_level_tracker.v
`timescale 1ns/1ps
`include "flic_defs.vh"

module flic_level_tracker (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire       push_in,
  input  wire [1:0] push_level_in,
  input  wire       pop_in,
  output reg  [3:0] in_service_out,
  output wire       any_active_out,
  output reg  [1:0] top_level_out
);

  // Bit n set: a handler of level value n is running (3 = highest)
  reg [3:0] clr_mask;
  integer   i;

  always @* begin
    top_level_out = 2'h0;
    for (i = 0; i < 4; i = i + 1)
      if (in_service_out[i])
        top_level_out = i[1:0];
    clr_mask = 4'h0;
    clr_mask[top_level_out] = 1'b1;
  end

  assign any_active_out = |in_service_out;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in)
      in_service_out <= 4'h0;
    else if (push_in)
      in_service_out <= in_service_out | (4'h1 << push_level_in);
    else if (pop_in)
      in_service_out <= in_service_out & ~clr_mask;
  end

endmodule

// >>> hdl/flic_core.v
// Functional notes
// - External inputs select level or edge trigger
// - Vectoring clears external flag only in edge
// - Timer A/B overflow cleared on vectoring
// - Serial A request ORs rx/tx, never auto-cleared
// - Serial B request ORs rx/tx, never auto-cleared
// - Timer C ORs overflow, external, low flags
// - Timer D ORs overflow, external, low flags
// - SPI done flag persists until software clears
// - ADC done/window/sample flags form request
// - Array request ORs counter and module flags
// - System flags ORed, tx added when redirected
// - Keypad match flag persists through vectoring
// - Two-wire state flag not auto-cleared
// - Software set/clear acts like hardware
// - Individual enables gated by global enable
// - Priority from high/low bit pairs
// - Higher level never preempted by lower
// - Same level resolved by polling order
// - Poll by source number, lowest first
// - Vector 0003H plus eight per source
// - DMA request ORs complete and timer flags
// - Sample, poll next cycle, then call
// - Block while equal/higher level in service
// - Vector only on last instruction cycle
// - One instruction after return or config write
`timescale 1ns/1ps
`include "flic_defs.vh"

module flic_core #(
  parameter NUM_SRC = `FLIC_NUM_SRC
) (
  input  wire               clk_sys_in,
  input  wire               rst_n_in,
  input  wire [2:0]         ext_irq_pin_in,
  input  wire [2:0]         ext_high_active_in,
  input  wire [2:0]         ext_type_select_in,
  input  wire [2:0]         ext_flag_set_in,
  input  wire [2:0]         ext_flag_clr_in,
  input  wire               timer_a_overflow_in,
  input  wire               timer_b_overflow_in,
  input  wire               timer_a_flag_wr_in,
  input  wire               timer_b_flag_wr_in,
  input  wire               timer_a_flag_wdata_in,
  input  wire               timer_b_flag_wdata_in,
  input  wire               serial_a_rx_flag_in,
  input  wire               serial_a_tx_flag_in,
  input  wire               serial_b_rx_flag_in,
  input  wire               serial_b_tx_flag_in,
  input  wire               timer_c_overflow_flag_in,
  input  wire               timer_c_external_flag_in,
  input  wire               timer_c_low_overflow_flag_in,
  input  wire               timer_d_overflow_flag_in,
  input  wire               timer_d_external_flag_in,
  input  wire               timer_d_low_overflow_flag_in,
  input  wire               spi_done_flag_in,
  input  wire               conversion_done_flag_in,
  input  wire               conversion_window_flag_in,
  input  wire               sample_flag_in,
  input  wire               array_counter_overflow_flag_in,
  input  wire [7:0]         array_module_flag_in,
  input  wire               rtc_overflow_flag_in,
  input  wire               brownout_a_flag_in,
  input  wire               brownout_b_flag_in,
  input  wire               watchdog_overflow_flag_in,
  input  wire               serial_start_detect_flag_in,
  input  wire               serial_stop_detect_flag_in,
  input  wire               sysflag_extra_a_in,
  input  wire               sysflag_extra_b_in,
  input  wire               tx_redirect_enable_in,
  input  wire               keypad_match_flag_in,
  input  wire               twi_state_flag_in,
  input  wire               dma_complete_flag_in,
  input  wire               timer_e_overflow_flag_in,
  input  wire               timer_f_overflow_flag_in,
  input  wire               global_irq_enable_in,
  input  wire [NUM_SRC-1:0] source_enable_in,
  input  wire [NUM_SRC-1:0] priority_high_in,
  input  wire [NUM_SRC-1:0] priority_low_in,
  input  wire               instr_last_cycle_in,
  input  wire               instr_is_return_in,
  input  wire               instr_cfg_write_in,
  output wire [2:0]         ext_request_flag_out,
  output reg                timer_a_overflow_flag_out,
  output reg                timer_b_overflow_flag_out,
  output reg                hardware_long_call_out,
  output reg  [15:0]        vector_addr_out,
  output reg  [4:0]         vector_source_out,
  output wire [3:0]         in_service_out
);

  //////////////////////////////////////////////////////////////////////////
  // Vector address from source number
  function [15:0] vec_of;
    input [4:0] src;
    begin
      vec_of = `FLIC_VEC_BASE + ({11'h000, src} << `FLIC_VEC_STEP_SH);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Request flags
  reg  [NUM_SRC-1:0] req_raw;
  reg  [NUM_SRC-1:0] req_q;
  wire               take;
  reg  [4:0]         win_src;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ext
      flic_ext_input u_ext (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .pin_in          (ext_irq_pin_in[g]),
        .high_active_in  (ext_high_active_in[g]),
        .type_select_in  (ext_type_select_in[g]),
        .sw_set_in       (ext_flag_set_in[g]),
        .sw_clr_in       (ext_flag_clr_in[g]),
        .vector_taken_in (take && win_src == (g == 0 ? `FLIC_SRC_EXT_A :
                                              g == 1 ? `FLIC_SRC_EXT_B :
                                                       `FLIC_SRC_EXT_C)),
        .flag_out        (ext_request_flag_out[g])
      );
    end
  endgenerate

  // Timer A/B overflow flags held here; software write has hardware effect
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      timer_a_overflow_flag_out <= 1'b0;
      timer_b_overflow_flag_out <= 1'b0;
    end else begin
      if (timer_a_overflow_in)
        timer_a_overflow_flag_out <= 1'b1;
      else if (timer_a_flag_wr_in)
        timer_a_overflow_flag_out <= timer_a_flag_wdata_in;
      else if (take && win_src == `FLIC_SRC_TMR_A)
        timer_a_overflow_flag_out <= 1'b0;
      if (timer_b_overflow_in)
        timer_b_overflow_flag_out <= 1'b1;
      else if (timer_b_flag_wr_in)
        timer_b_overflow_flag_out <= timer_b_flag_wdata_in;
      else if (take && win_src == `FLIC_SRC_TMR_B)
        timer_b_overflow_flag_out <= 1'b0;
    end
  end

  // Request gathering; flags owned by peripherals are never cleared here
  always @* begin
    req_raw = {NUM_SRC{1'b0}};
    req_raw[`FLIC_SRC_EXT_A]  = ext_request_flag_out[0];
    req_raw[`FLIC_SRC_TMR_A]  = timer_a_overflow_flag_out;
    req_raw[`FLIC_SRC_EXT_B]  = ext_request_flag_out[1];
    req_raw[`FLIC_SRC_TMR_B]  = timer_b_overflow_flag_out;
    req_raw[`FLIC_SRC_SER_A]  = serial_a_rx_flag_in | serial_a_tx_flag_in;
    req_raw[`FLIC_SRC_TMR_C]  = timer_c_overflow_flag_in | timer_c_external_flag_in |
                                timer_c_low_overflow_flag_in;
    req_raw[`FLIC_SRC_EXT_C]  = ext_request_flag_out[2];
    req_raw[`FLIC_SRC_SPI]    = spi_done_flag_in;
    req_raw[`FLIC_SRC_ADC]    = conversion_done_flag_in | conversion_window_flag_in |
                                sample_flag_in;
    req_raw[`FLIC_SRC_ARRAY]  = array_counter_overflow_flag_in |
                                (|array_module_flag_in);
    req_raw[`FLIC_SRC_SYSF]   = rtc_overflow_flag_in | brownout_a_flag_in |
                                brownout_b_flag_in | watchdog_overflow_flag_in |
                                serial_start_detect_flag_in | serial_stop_detect_flag_in |
                                sysflag_extra_a_in | sysflag_extra_b_in |
                                (serial_a_tx_flag_in & tx_redirect_enable_in);
    req_raw[`FLIC_SRC_KEYPAD] = keypad_match_flag_in;
    req_raw[`FLIC_SRC_TWI]    = twi_state_flag_in;
    req_raw[`FLIC_SRC_SER_B]  = serial_b_rx_flag_in | serial_b_tx_flag_in;
    req_raw[`FLIC_SRC_TMR_D]  = timer_d_overflow_flag_in | timer_d_external_flag_in |
                                timer_d_low_overflow_flag_in;
    req_raw[`FLIC_SRC_DMA]    = dma_complete_flag_in | timer_e_overflow_flag_in |
                                timer_f_overflow_flag_in;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample stage
  always @(posedge clk_sys_in) begin
    if (!rst_n_in)
      req_q <= {NUM_SRC{1'b0}};
    else
      req_q <= req_raw & source_enable_in & ~`FLIC_RESERVED_MSK
               & {NUM_SRC{global_irq_enable_in}};
  end

  //////////////////////////////////////////////////////////////////////////
  // Arbitration: highest level, then lowest source number
  reg  [1:0] win_lvl;
  reg        win_valid;
  reg  [1:0] lvl;
  integer    s;

  always @* begin
    win_valid = 1'b0;
    win_lvl   = `FLIC_LVL_RST;
    win_src   = 5'h00;
    lvl       = 2'h0;
    for (s = NUM_SRC - 1; s >= 0; s = s - 1) begin
      lvl = {priority_high_in[s], priority_low_in[s]};
      if (req_q[s] && (!win_valid || lvl >= win_lvl)) begin
        win_valid = 1'b1;
        win_lvl   = lvl;
        win_src   = s[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Block conditions
  wire [3:0] svc;
  wire       svc_any;
  wire [1:0] svc_top;
  reg        hold_q;

  // One instruction must finish after return or config write
  always @(posedge clk_sys_in) begin
    if (!rst_n_in)
      hold_q <= 1'b0;
    else if (instr_last_cycle_in)
      hold_q <= instr_is_return_in | instr_cfg_write_in;
  end

  assign take = win_valid
                && global_irq_enable_in
                && instr_last_cycle_in
                && !instr_is_return_in && !instr_cfg_write_in && !hold_q
                && (!svc_any || win_lvl > svc_top);

  flic_level_tracker u_lvl (
    .clk_sys_in     (clk_sys_in),
    .rst_n_in       (rst_n_in),
    .push_in        (take),
    .push_level_in  (win_lvl),
    .pop_in         (instr_is_return_in & instr_last_cycle_in),
    .in_service_out (svc),
    .any_active_out (svc_any),
    .top_level_out  (svc_top)
  );

  assign in_service_out = svc;

  //////////////////////////////////////////////////////////////////////////
  // Call output
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      hardware_long_call_out <= 1'b0;
      vector_addr_out        <= 16'h0000;
      vector_source_out      <= 5'h00;
    end else begin
      hardware_long_call_out <= take;
      if (take) begin
        vector_addr_out   <= vec_of(win_src);
        vector_source_out <= win_src;
      end
    end
  end

endmodule

// >>> sim/flic_cpu_model.sv
`timescale 1ns/1ps
module flic_cpu_model (
  input  wire clk_sys_in,
  input  wire rst_n_in,
  input  wire slow_in,
  input  wire ret_req_in,
  input  wire cfg_req_in,
  output wire last_out,
  output wire ret_out,
  output wire cfg_out
);
  logic [1:0] cnt_q;
  // Slow mode stretches each instruction to three cycles
  always @(negedge clk_sys_in) begin
    if (!rst_n_in || cnt_q == 2'h0)
      cnt_q <= slow_in ? 2'h2 : 2'h0;
    else
      cnt_q <= cnt_q - 2'h1;
  end
  assign last_out = (cnt_q == 2'h0);
  assign ret_out  = last_out & ret_req_in;
  assign cfg_out  = last_out & cfg_req_in;
endmodule

// >>> sim/flic_core_sva.sv
`timescale 1ns/1ps
module flic_core_sva (
  input wire        clk_sys_in,
  input wire        rst_n_in,
  input wire        global_irq_enable_in,
  input wire        instr_last_cycle_in,
  input wire        instr_is_return_in,
  input wire        instr_cfg_write_in,
  input wire        timer_a_overflow_in,
  input wire        timer_a_flag_wr_in,
  input wire        timer_a_overflow_flag_out,
  input wire        hardware_long_call_out,
  input wire [15:0] vector_addr_out,
  input wire [4:0]  vector_source_out,
  input wire [3:0]  in_service_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire       call = hardware_long_call_out;
  wire [4:0] src  = vector_source_out;
  a_call_one_cycle: assert property (call |=> !call) else $error("call too long");
  a_call_at_end: assert property (call |-> $past(instr_last_cycle_in)) else $error("mid call");
  a_global_gate: assert property (call |-> $past(global_irq_enable_in)) else $error("ea off");
  a_vector_map: assert property (call |-> vector_addr_out == 16'h0003 + {8'h00, src, 3'h0})
    else $error("bad vector");
  a_no_reserved: assert property (call |-> src <= 5'h12 && !(src inside {5'h0d, 5'h0f, 5'h11}))
    else $error("reserved source");
  a_vector_holds: assert property (!call |-> $stable(vector_addr_out) && $stable(src))
    else $error("vector moved");
  a_hold_after_ret: assert property (call |-> !$past(instr_is_return_in, 2)
    && !$past(instr_cfg_write_in, 2) && !$past(instr_is_return_in)
    && !$past(instr_cfg_write_in)) else $error("no gap");
  a_timer_set: assert property ($past(timer_a_overflow_in) |-> timer_a_overflow_flag_out)
    else $error("overflow lost");
  a_timer_clear: assert property (call && src == 5'h01 && !$past(timer_a_overflow_in)
    && !$past(timer_a_flag_wr_in) |-> !timer_a_overflow_flag_out) else $error("no clear");
  a_level_record: assert property (call |-> in_service_out != 4'h0) else $error("no level");
  c_call: cover property (call);
  c_timer: cover property (call && src == 5'h01);
  c_nested: cover property (call && in_service_out[3] && in_service_out[0]);
endmodule
bind flic_core flic_core_sva u_sva (.*);

// >>> sim/test_four_level_interrupt_controller.sv
`timescale 1ns/1ps
module test_four_level_interrupt_controller;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, slow = 1'b0, ret_req = 1'b0, cfg_req = 1'b0;
  logic [2:0]  ext_irq_pin_in = 3'h0, ext_high_active_in = 3'h7, ext_type_select_in = 3'h7;
  logic [2:0]  ext_flag_set_in = 3'h0, ext_flag_clr_in = 3'h0;
  logic        timer_a_overflow_in = 1'b0, timer_b_overflow_in = 1'b0;
  logic        timer_a_flag_wr_in = 1'b0, timer_b_flag_wr_in = 1'b0;
  logic        timer_a_flag_wdata_in = 1'b0, timer_b_flag_wdata_in = 1'b0;
  logic        tx_redirect_enable_in = 1'b0, global_irq_enable_in = 1'b1;
  logic [18:0] source_enable_in = 19'h7ffff, priority_high_in = 19'h0, priority_low_in = 19'h0;
  logic [35:0] pf = 36'h0;
  int          n_errors = 0, num_checks = 0;
  wire serial_a_rx_flag_in = pf[0], serial_a_tx_flag_in = pf[1], serial_b_rx_flag_in = pf[2];
  wire serial_b_tx_flag_in = pf[3], timer_c_overflow_flag_in = pf[4];
  wire timer_c_external_flag_in = pf[5], timer_c_low_overflow_flag_in = pf[6];
  wire timer_d_overflow_flag_in = pf[7], timer_d_external_flag_in = pf[8];
  wire timer_d_low_overflow_flag_in = pf[9], spi_done_flag_in = pf[10];
  wire conversion_done_flag_in = pf[11], conversion_window_flag_in = pf[12];
  wire sample_flag_in = pf[13], array_counter_overflow_flag_in = pf[14];
  wire rtc_overflow_flag_in = pf[15], brownout_a_flag_in = pf[16], brownout_b_flag_in = pf[17];
  wire watchdog_overflow_flag_in = pf[18], serial_start_detect_flag_in = pf[19];
  wire serial_stop_detect_flag_in = pf[20], sysflag_extra_a_in = pf[21];
  wire sysflag_extra_b_in = pf[22], keypad_match_flag_in = pf[23], twi_state_flag_in = pf[24];
  wire dma_complete_flag_in = pf[25], timer_e_overflow_flag_in = pf[26];
  wire timer_f_overflow_flag_in = pf[27];
  wire [7:0]  array_module_flag_in = pf[35:28];
  wire        instr_last_cycle_in, instr_is_return_in, instr_cfg_write_in;
  wire [2:0]  ext_request_flag_out;
  wire        timer_a_overflow_flag_out, timer_b_overflow_flag_out, hardware_long_call_out;
  wire [15:0] vector_addr_out;
  wire [4:0]  vector_source_out;
  wire [3:0]  in_service_out;
  flic_core dut (.*);
  flic_cpu_model u_cpu (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .ret_req_in(ret_req), .cfg_req_in(cfg_req), .last_out(instr_last_cycle_in),
    .ret_out(instr_is_return_in), .cfg_out(instr_cfg_write_in));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_call(input int n, output logic got);
    got = 1'b0;
    for (int k = 0; k < n && !got; k++) begin
      @(posedge clk_sys_in);
      #1;
      got = (hardware_long_call_out === 1'b1);
    end
  endtask
  task automatic expect_call(input logic [4:0] src);
    logic got;
    wait_call(40, got);
    chk(got, 1'b1);
    chk(vector_source_out, src);
    chk(vector_addr_out, 16'h0003 + {8'h00, src, 3'h0});
  endtask
  task automatic expect_none(input int n);
    logic got;
    wait_call(n, got);
    chk(got, 1'b0);
  endtask
  task automatic do_return;
    @(negedge clk_sys_in);
    ret_req = 1'b1;
    @(posedge clk_sys_in iff instr_last_cycle_in);
    @(negedge clk_sys_in);
    ret_req = 1'b0;
  endtask
  function automatic logic [4:0] src_of(input int i);
    if (i < 2) return 5'h04;
    if (i < 4) return 5'h0e;
    if (i < 7) return 5'h05;
    if (i < 10) return 5'h10;
    if (i == 10) return 5'h07;
    if (i < 14) return 5'h08;
    if (i == 14 || i > 27) return 5'h09;
    if (i < 23) return 5'h0a;
    if (i == 23) return 5'h0b;
    if (i == 24) return 5'h0c;
    return 5'h12;
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_walk;
    @(negedge clk_sys_in);
    pf[10] = 1'b1;
    expect_call(5'h07);
    chk(in_service_out, 4'h1);
    expect_none(10);
    do_return;
    chk(in_service_out, 4'h0);
    expect_none(1);
    expect_call(5'h07);
    @(negedge clk_sys_in);
    pf[10] = 1'b0;
    do_return;
  endtask
  task automatic t_enable;
    global_irq_enable_in = 1'b0;
    pf[2] = 1'b1;
    expect_none(20);
    @(negedge clk_sys_in);
    global_irq_enable_in = 1'b1;
    source_enable_in[14] = 1'b0;
    expect_none(20);
    @(negedge clk_sys_in);
    source_enable_in[14] = 1'b1;
    cfg_req = 1'b1;
    @(posedge clk_sys_in iff instr_last_cycle_in);
    @(negedge clk_sys_in);
    cfg_req = 1'b0;
    expect_none(1);
    expect_call(5'h0e);
    @(negedge clk_sys_in);
    pf[2] = 1'b0;
    do_return;
  endtask
  task automatic t_prio;
    pf[0] = 1'b1;
    pf[4] = 1'b1;
    expect_call(5'h04);
    expect_none(5);
    @(negedge clk_sys_in);
    priority_high_in[5] = 1'b1;
    priority_low_in[5] = 1'b1;
    expect_call(5'h05);
    chk(in_service_out, 4'h9);
    @(negedge clk_sys_in);
    pf[4] = 1'b0;
    do_return;
    chk(in_service_out, 4'h1);
    priority_low_in[5] = 1'b0;
    priority_low_in[4] = 1'b1;
    pf[4] = 1'b1;
    do_return;
    expect_call(5'h05);
    chk(in_service_out, 4'h4);
    expect_none(10);
    @(negedge clk_sys_in);
    pf[4] = 1'b0;
    pf[0] = 1'b0;
    priority_low_in = 19'h0;
    priority_high_in = 19'h0;
    do_return;
  endtask
  task automatic t_timer;
    timer_a_overflow_in = 1'b1;
    @(negedge clk_sys_in);
    timer_a_overflow_in = 1'b0;
    expect_call(5'h01);
    chk(timer_a_overflow_flag_out, 1'b0);
    do_return;
    timer_a_flag_wr_in = 1'b1;
    timer_a_flag_wdata_in = 1'b1;
    @(negedge clk_sys_in);
    timer_a_flag_wr_in = 1'b0;
    expect_call(5'h01);
    do_return;
    timer_b_overflow_in = 1'b1;
    @(negedge clk_sys_in);
    timer_b_overflow_in = 1'b0;
    expect_call(5'h03);
    chk(timer_b_overflow_flag_out, 1'b0);
    do_return;
  endtask
  task automatic t_ext;
    ext_irq_pin_in[0] = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    ext_irq_pin_in[0] = 1'b0;
    expect_call(5'h00);
    chk(ext_request_flag_out[0], 1'b0);
    do_return;
    ext_type_select_in[0] = 1'b0;
    ext_irq_pin_in[0] = 1'b1;
    expect_call(5'h00);
    chk(ext_request_flag_out[0], 1'b1);
    @(negedge clk_sys_in);
    ext_irq_pin_in[0] = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    chk(ext_request_flag_out[0], 1'b0);
    global_irq_enable_in = 1'b0;
    ext_flag_set_in[1] = 1'b1;
    @(negedge clk_sys_in);
    ext_flag_set_in[1] = 1'b0;
    chk(ext_request_flag_out[1], 1'b1);
    ext_flag_clr_in[1] = 1'b1;
    @(negedge clk_sys_in);
    ext_flag_clr_in[1] = 1'b0;
    chk(ext_request_flag_out[1], 1'b0);
    do_return;
    global_irq_enable_in = 1'b1;
    expect_none(10);
    @(negedge clk_sys_in);
    ext_flag_set_in[2] = 1'b1;
    @(negedge clk_sys_in);
    ext_flag_set_in[2] = 1'b0;
    expect_call(5'h06);
    chk(ext_request_flag_out[2], 1'b0);
    do_return;
    // Low-active edge: the falling pin must request
    ext_high_active_in[2] = 1'b0;
    ext_irq_pin_in[2] = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    ext_irq_pin_in[2] = 1'b0;
    expect_call(5'h06);
    chk(ext_request_flag_out[2], 1'b0);
    do_return;
  endtask
  task automatic t_groups;
    for (int i = 0; i < 36; i++) begin
      @(negedge clk_sys_in);
      slow <= i[0];
      pf[i] = 1'b1;
      expect_call(src_of(i));
      @(negedge clk_sys_in);
      pf[i] = 1'b0;
      do_return;
    end
    slow <= 1'b0;
    source_enable_in[4] = 1'b0;
    tx_redirect_enable_in = 1'b1;
    pf[1] = 1'b1;
    expect_call(5'h0a);
    @(negedge clk_sys_in);
    pf[1] = 1'b0;
    do_return;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    t_walk;
    t_enable;
    t_prio;
    t_timer;
    t_ext;
    t_groups;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    stop_test;
  end
endmodule
